// >>> hdl/pulse_counter.sv
// pulse_counter: 32-bit pulse counter with compare output, preload,
// limit wrap and overflow/underflow flags behind an apb slave.
// assumes count and direction pins asynchronous to pclk, pclk 50 MHz.
//
// Overview of operation
// - output 1 on when count reaches on threshold
// - output 1 off when count reaches off threshold
// - downward, below on threshold turns output off
// - output 2 follows software bit only
// - no compare switching while enable is false
// - enabling switches output at once if met
// - threshold change acts without waiting for counts
// - load strobe copies preload into counter
// - wrap enabled, up: limit goes to zero
// - wrap enabled, down: zero reloads limit
// - unsigned 32-bit count wraps at both ends
// - wrap sets flag; fixed values clear flags
// - limit acts only while wrap enable true
// - up/down mode: input 2 high counts up
// - exactly one of three counting modes; mode code 3 counts nothing
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

module pulse_counter
    import counter_pkg::*;
(
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire apb_req_s apb_req,
    output apb_rsp_s      apb_rsp,
    input  wire logic     cnt_pin,
    input  wire logic     dir_pin,
    output logic          out1,
    output logic          out2
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] count;           // counter value
        logic        ovf;             // overflow flag
        logic        unf;             // underflow flag
        logic        out1;            // compare output
        logic        out2;            // software output
        logic        cmp_en;          // compare output enable
        logic        wrap_en;         // limit wrap enable
        logic [1:0]  mode;            // counting mode
        logic        load_pend;       // load strobe seen last cycle
        logic [31:0] on_thr;          // switch-on threshold
        logic [31:0] off_thr;         // switch-off threshold
        logic [31:0] preload;         // value for load strobe
        logic [31:0] limit;           // wrap limit
        logic [31:0] rdata;           // read data for access phase
    } state_s;

    state_s s_reg;                    // registered state
    state_s s_next;                   // next state

    logic [1:0]  pin_level;           // synchronised pin levels
    logic [1:0]  pin_rise;            // rising edges of pins
    logic        step_up;             // count one up this cycle
    logic        step_dn;             // count one down this cycle
    logic        cmp_active;          // compare says output on
    logic        wr_acc;              // apb write access phase
    logic        rd_setup;            // apb read setup phase
    logic        addr_ok;             // address is mapped
    logic [31:0] ctrl_word;           // control register image
    logic [31:0] stat_word;           // status register image

    // ------------------------------------------------------------------
    // pin synchronisers: bit 0 count pulse, bit 1 direction
    // ------------------------------------------------------------------
    pin_sync #(
        .WIDTH (2)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     ({dir_pin, cnt_pin}),
        .level   (pin_level),
        .rise    (pin_rise)
    );

    // ------------------------------------------------------------------
    // count direction decode
    // ------------------------------------------------------------------
    // a pulse is a rising edge on the count pin; illegal mode code counts
    // nothing, so only one mode is ever in force
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        unique case (s_reg.mode)
            MODE_EXT: begin
                step_up = pin_rise[0] & pin_level[1];
                step_dn = pin_rise[0] & ~pin_level[1];
            end
            MODE_UP:   step_up = pin_rise[0];
            MODE_DOWN: step_dn = pin_rise[0];
            default: begin
                step_up = 1'b0;
                step_dn = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // compare: level test on the registered count
    // ------------------------------------------------------------------
    // on from the on threshold up to the off threshold; with the off
    // threshold below the on threshold the output stays on above on.
    // equal thresholds keep the output off.
    always_comb begin
        cmp_active = (s_reg.count >= s_reg.on_thr) &&
                     ((s_reg.count < s_reg.off_thr) ||
                      (s_reg.off_thr < s_reg.on_thr));
    end

    // ------------------------------------------------------------------
    // bus decode and register images
    // ------------------------------------------------------------------
    assign wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

    always_comb begin
        ctrl_word = RST_WORD;
        ctrl_word[CTRL_CMP_EN]  = s_reg.cmp_en;
        ctrl_word[CTRL_OUT2]    = s_reg.out2;
        ctrl_word[CTRL_WRAP_EN] = s_reg.wrap_en;
        ctrl_word[CTRL_MODE_LO +: 2] = s_reg.mode;
        stat_word = RST_WORD;
        stat_word[STAT_OVF]  = s_reg.ovf;
        stat_word[STAT_UNF]  = s_reg.unf;
        stat_word[STAT_OUT1] = s_reg.out1;
        stat_word[STAT_OUT2] = s_reg.out2;
    end

    // mapped word addresses only
    always_comb begin
        unique case (apb_req.paddr)
            OFF_CTRL, OFF_ON_THR, OFF_OFF_THR, OFF_PRELOAD,
            OFF_LIMIT, OFF_COUNT, OFF_STATUS: addr_ok = 1'b1;
            default:                          addr_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.load_pend = 1'b0;

        // register writes take effect at the end of the access phase
        if (wr_acc) begin
            unique case (apb_req.paddr)
                OFF_CTRL: begin
                    s_next.cmp_en  = apb_req.pwdata[CTRL_CMP_EN];
                    s_next.out2    = apb_req.pwdata[CTRL_OUT2];
                    s_next.wrap_en = apb_req.pwdata[CTRL_WRAP_EN];
                    s_next.mode    = apb_req.pwdata[CTRL_MODE_LO +: 2];
                    s_next.load_pend = apb_req.pwdata[CTRL_LOAD];
                end
                OFF_ON_THR:  s_next.on_thr  = apb_req.pwdata;
                OFF_OFF_THR: s_next.off_thr = apb_req.pwdata;
                OFF_PRELOAD: s_next.preload = apb_req.pwdata;
                OFF_LIMIT:   s_next.limit   = apb_req.pwdata;
                default: begin
                end
            endcase
        end

        // counter: load strobe wins over a pulse in the same cycle;
        // the preload register itself never touches the count
        if (s_reg.load_pend) begin
            s_next.count = s_reg.preload;
        end else if (step_up) begin
            if (s_reg.wrap_en && s_reg.count == s_reg.limit) begin
                s_next.count = RST_WORD;
                s_next.ovf   = 1'b1;
                s_next.unf   = 1'b0;
            end else if (s_reg.count == CNT_MAX) begin
                s_next.count = RST_WORD;
                s_next.ovf   = 1'b1;
                s_next.unf   = 1'b0;
            end else begin
                s_next.count = s_reg.count + 32'h0000_0001;
                if (s_next.count == FLAG_CLR_UP) begin
                    s_next.ovf = 1'b0;
                    s_next.unf = 1'b0;
                end
            end
        end else if (step_dn) begin
            if (s_reg.wrap_en && s_reg.count == RST_WORD) begin
                s_next.count = s_reg.limit;
                s_next.unf   = 1'b1;
                s_next.ovf   = 1'b0;
            end else if (s_reg.count == RST_WORD) begin
                s_next.count = CNT_MAX;
                s_next.unf   = 1'b1;
                s_next.ovf   = 1'b0;
            end else begin
                s_next.count = s_reg.count - 32'h0000_0001;
                if (s_next.count == FLAG_CLR_DN) begin
                    s_next.ovf = 1'b0;
                    s_next.unf = 1'b0;
                end
            end
        end

        // output 1 follows the compare every cycle while enabled, so an
        // enable or threshold change acts at once; disabled it holds
        if (s_reg.cmp_en) begin
            s_next.out1 = cmp_active;
        end else begin
            s_next.out1 = s_reg.out1;
        end

        // read data captured in the setup phase, ready in access phase
        if (rd_setup) begin
            unique case (apb_req.paddr)
                OFF_CTRL:    s_next.rdata = ctrl_word;
                OFF_ON_THR:  s_next.rdata = s_reg.on_thr;
                OFF_OFF_THR: s_next.rdata = s_reg.off_thr;
                OFF_PRELOAD: s_next.rdata = s_reg.preload;
                OFF_LIMIT:   s_next.rdata = s_reg.limit;
                OFF_COUNT:   s_next.rdata = s_reg.count;
                OFF_STATUS:  s_next.rdata = stat_word;
                default:     s_next.rdata = RST_WORD;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // zero wait states: ready in every access phase, error on unmapped
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~addr_ok;
    assign apb_rsp.prdata  = s_reg.rdata;
    assign out1            = s_reg.out1;
    assign out2            = s_reg.out2;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence up_at_limit;
        !s_reg.load_pend && step_up && s_reg.wrap_en &&
        s_reg.count == s_reg.limit;
    endsequence

    sequence dn_at_zero;
        !s_reg.load_pend && step_dn && s_reg.wrap_en &&
        s_reg.count == RST_WORD;
    endsequence

    sequence ctrl_write;
        wr_acc && apb_req.paddr == OFF_CTRL;
    endsequence

    a_load_takes_preload: assert property (
        s_reg.load_pend |=> s_reg.count == $past(s_reg.preload))
        else $error("load strobe did not copy preload");

    a_out1_hold_disabled: assert property (
        !s_reg.cmp_en |=> out1 == $past(out1))
        else $error("output 1 moved while compare disabled");

    a_out1_on_window: assert property (
        s_reg.cmp_en && s_reg.count >= s_reg.on_thr &&
        s_reg.count < s_reg.off_thr |=> out1)
        else $error("output 1 not on at on threshold");

    a_out1_off_thr: assert property (
        s_reg.cmp_en && s_reg.off_thr > s_reg.on_thr &&
        s_reg.count >= s_reg.off_thr |=> !out1)
        else $error("output 1 not off at off threshold");

    a_out1_below_on: assert property (
        s_reg.cmp_en && s_reg.count < s_reg.on_thr |=> !out1)
        else $error("output 1 on below on threshold");

    a_out2_soft_bit: assert property (
        ctrl_write |=> out2 == $past(apb_req.pwdata[CTRL_OUT2])
                       ##1 out2 == $past(out2))
        else $error("output 2 not following software bit");

    a_wrap_up_limit: assert property (
        up_at_limit |=> s_reg.count == RST_WORD && s_reg.ovf &&
                        !s_reg.unf)
        else $error("up wrap at limit wrong");

    a_wrap_dn_limit: assert property (
        dn_at_zero |=> s_reg.count == $past(s_reg.limit) && s_reg.unf &&
                       !s_reg.ovf)
        else $error("down wrap at zero wrong");

    a_full_wrap_up: assert property (
        !s_reg.load_pend && step_up && !s_reg.wrap_en &&
        s_reg.count == CNT_MAX |=> s_reg.count == RST_WORD && s_reg.ovf)
        else $error("32-bit up wrap wrong");

    a_flag_clear_up: assert property (
        !s_reg.load_pend && step_up &&
        s_reg.count == FLAG_CLR_UP - 32'h0000_0001 &&
        !(s_reg.wrap_en && s_reg.count == s_reg.limit)
        |=> !s_reg.ovf && !s_reg.unf)
        else $error("flags not cleared upward");

    a_ext_dir_up: assert property (
        s_reg.mode == MODE_EXT && pin_rise[0] && pin_level[1] &&
        !s_reg.load_pend && !s_reg.wrap_en && s_reg.count != CNT_MAX
        |=> s_reg.count == $past(s_reg.count) + 32'h0000_0001)
        else $error("external direction up count wrong");

    a_ext_dir_dn: assert property (
        s_reg.mode == MODE_EXT && pin_rise[0] && !pin_level[1] &&
        !s_reg.load_pend && s_reg.count != RST_WORD
        |=> s_reg.count == $past(s_reg.count) - 32'h0000_0001)
        else $error("external direction down count wrong");

    a_flag_clear_dn: assert property (
        !s_reg.load_pend && step_dn &&
        s_reg.count == FLAG_CLR_DN + 32'h0000_0001
        |=> !s_reg.ovf && !s_reg.unf)
        else $error("flags not cleared downward");

    a_mode_idle: assert property (
        s_reg.mode == 2'h3 && !s_reg.load_pend
        |=> s_reg.count == $past(s_reg.count))
        else $error("count moved in idle mode");

    a_out1_enable_now: assert property (
        $rose(s_reg.cmp_en) && cmp_active |=> out1)
        else $error("output 1 not switched on enable");

endmodule

`default_nettype wire

// >>> hdl/counter_pkg.sv
// counter_pkg: register map, field layout, reset values and bus carriers
// for the pulse counter with compare output.
// assumes a 32-bit apb slave and a single 50 MHz clock.

package counter_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL    = 8'h00; // enables, mode, load
    localparam logic [7:0] OFF_ON_THR  = 8'h04; // switch-on threshold
    localparam logic [7:0] OFF_OFF_THR = 8'h08; // switch-off threshold
    localparam logic [7:0] OFF_PRELOAD = 8'h0c; // value for load strobe
    localparam logic [7:0] OFF_LIMIT   = 8'h10; // wrap limit
    localparam logic [7:0] OFF_COUNT   = 8'h14; // counter value, read only
    localparam logic [7:0] OFF_STATUS  = 8'h18; // flags, read only

    // ------------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------------
    localparam int CTRL_CMP_EN  = 0;  // compare output enable
    localparam int CTRL_OUT2    = 1;  // output 2 level
    localparam int CTRL_WRAP_EN = 2;  // limit wrap enable
    localparam int CTRL_MODE_LO = 4;  // counting mode, two bits
    localparam int CTRL_LOAD    = 8;  // load strobe, write one, reads zero

    // status field positions
    localparam int STAT_OVF  = 0;     // overflow flag
    localparam int STAT_UNF  = 1;     // underflow flag
    localparam int STAT_OUT1 = 2;     // output 1 level
    localparam int STAT_OUT2 = 3;     // output 2 level

    // ------------------------------------------------------------------
    // reset values and counter constants
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
    localparam logic [31:0] CNT_MAX     = 32'hffff_ffff;
    localparam logic [31:0] FLAG_CLR_UP = 32'h0000_4000;
    localparam logic [31:0] FLAG_CLR_DN = 32'hffff_c000;

    // counting modes
    typedef enum logic [1:0] {
        MODE_EXT  = 2'h0,             // direction from input 2
        MODE_UP   = 2'h1,             // up only
        MODE_DOWN = 2'h2              // down only
    } mode_e;

    // apb request and answer carriers
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

endpackage

// >>> hdl/pin_sync.sv
// pin_sync: two-stage synchroniser per input pin plus rising edge pulse.
// assumes pins are asynchronous to pclk and change slower than pclk.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);

    // ------------------------------------------------------------------
    // per-pin synchroniser
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
            logic meta_reg;           // first stage, read only by second
            logic sync_reg;           // second stage, safe level
            logic last_reg;           // previous safe level
            // shift the pin through three flops
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                    last_reg <= 1'b0;
                end else begin
                    meta_reg <= pin[i];
                    sync_reg <= meta_reg;
                    last_reg <= sync_reg;
                end
            end
            assign level[i] = sync_reg;
            assign rise[i]  = sync_reg & ~last_reg;
        end
    endgenerate

endmodule

`default_nettype wire

// >>> test/pulse_src.sv
// pulse_src: far-side model that drives the count and direction pins.
// assumes a free-running pclk; pins change only just after rising edges.
`timescale 1ns/1ps
`default_nettype none

module pulse_src (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic [7:0] num,
    input  wire logic       up,
    input  wire logic       slow,
    output logic            cnt_pin,
    output logic            dir_pin,
    output logic            busy
);
    logic [7:0] left;  // pulses still to send
    logic [2:0] ph;    // phase inside one pulse

    assign busy = (left != 8'h00);

    // ------------------------------------------------------------------
    // pulse train: high two cycles, low three or six when slow
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left    <= 8'h00;
            ph      <= 3'h0;
            cnt_pin <= 1'b0;
            dir_pin <= 1'b0;
        end else if (start && !busy) begin
            // direction settles a cycle ahead of the first rise
            left    <= num;
            ph      <= 3'h0;
            dir_pin <= up;
        end else if (busy) begin
            ph <= ph + 3'h1;
            if (ph == 3'h0) begin
                cnt_pin <= 1'b1;
            end
            if (ph == 3'h2) begin
                cnt_pin <= 1'b0;
            end
            if (ph == (slow ? 3'h7 : 3'h4)) begin
                ph   <= 3'h0;
                left <= left - 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

// >>> test/counter_compare_output_reload_bench.sv
// counter_compare_output_reload_bench: self-checking bench for pulse_counter.
// assumes counter_pkg, pulse_counter and pulse_src are compiled first.
`timescale 1ns/1ps
`default_nettype none

module counter_compare_output_reload_bench
    import counter_pkg::*;
;
    logic        pclk;        // 50 MHz bus clock
    logic        presetn;     // active low reset
    apb_req_s    req;         // bus request
    apb_rsp_s    rsp;         // bus answer
    logic        cnt_pin;     // count pulse pin
    logic        dir_pin;     // direction pin
    logic        out1;        // compare output
    logic        out2;        // software output
    logic        start;       // pulse train request
    logic [7:0]  num;         // pulses per train
    logic        up;          // direction of the train
    logic        slow;        // slow pulse spacing
    logic        busy;        // train in progress
    logic [32:0] exp_q[$];    // expected {pslverr, prdata}
    logic [32:0] en;          // note taken off the queue
    logic [31:0] ctrl;        // shadow of the control word
    logic [31:0] rnd;         // random value
    int          fail_count;  // mismatches
    int          checks_done; // comparisons

    pulse_counter u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .cnt_pin(cnt_pin), .dir_pin(dir_pin),
        .out1(out1), .out2(out2));
    pulse_src u_src (.pclk(pclk), .presetn(presetn), .start(start),
        .num(num), .up(up), .slow(slow), .cnt_pin(cnt_pin),
        .dir_pin(dir_pin), .busy(busy));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one transfer: setup, access, hold until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1) @(posedge pclk);
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // reads note their expected answer for the monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic err = 1'b0);
        exp_q.push_back({err, e});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic setc(input logic [31:0] v);
        ctrl = v;
        wr(OFF_CTRL, ctrl);
    endtask

    // preload first, then the strobe
    task automatic ld(input logic [31:0] v);
        wr(OFF_PRELOAD, v);
        wr(OFF_CTRL, ctrl | 32'h100);
    endtask

    // send n pulses in mode m, then check count, flags and out1
    task automatic step(input logic [1:0] m, input logic u,
                        input logic [7:0] n, input logic [31:0] c,
                        input logic [2:0] f);
        setc({ctrl[31:6], m, ctrl[3:0]});
        num   <= n;
        up    <= u;
        slow  <= 1'($urandom % 2);
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        @(posedge pclk);
        while (busy === 1'b1) @(posedge pclk);
        repeat (5) @(posedge pclk);
        rd(OFF_COUNT, c);
        rd(OFF_STATUS, {28'h0, ctrl[1], f});
        chk("out1", {31'h0, f[2]}, {31'h0, out1});
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // clock, monitor and watchdog
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // read answers are compared with the oldest note
    always @(posedge pclk) begin
        if (req.psel && req.penable && !req.pwrite && rsp.pready) begin
            en = exp_q.pop_front();
            chk("prdata", en[31:0], rsp.prdata);
            chk("pslverr", {31'h0, en[32]}, {31'h0, rsp.pslverr});
        end
    end

    initial begin
        #200000;
        fail_count++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        req = '0;
        {start, num, up, slow} = '0;
        {fail_count, checks_done} = '0;
        ctrl = 32'h0;
        rnd = $urandom(64);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_CTRL, 32'h0);
        rd(OFF_STATUS, 32'h0);
        rd(OFF_LIMIT, 32'h0);
        rd(8'h1c, 32'h0, 1'b1);
        wr(OFF_COUNT, 32'h55);
        rd(OFF_COUNT, 32'h0);
        $display("test reset done");
        wr(OFF_ON_THR, 32'h12);
        wr(OFF_OFF_THR, 32'h15);
        setc(32'h11);
        rnd = $urandom;
        wr(OFF_PRELOAD, rnd);
        rd(OFF_COUNT, 32'h0);
        ld(rnd);
        rd(OFF_COUNT, rnd);
        ld(32'h10);
        $display("test load done");
        step(2'h1, 1'b1, 8'h2, 32'h12, 3'b100);
        step(2'h1, 1'b1, 8'h3, 32'h15, 3'b000);
        step(2'h0, 1'b0, 8'h1, 32'h14, 3'b100);
        step(2'h0, 1'b0, 8'h3, 32'h11, 3'b000);
        step(2'h0, 1'b1, 8'h2, 32'h13, 3'b100);
        step(2'h2, 1'b1, 8'h3, 32'h10, 3'b000);
        step(2'h3, 1'b1, 8'h2, 32'h10, 3'b000);
        $display("test compare done");
        setc(32'h10);
        ld(32'h13);
        rd(OFF_STATUS, 32'h0);
        setc(32'h11);
        rd(OFF_STATUS, 32'h4);
        wr(OFF_ON_THR, 32'h14);
        rd(OFF_STATUS, 32'h0);
        setc(32'h10);
        for (int i = 0; i < 4; i++) begin
            rnd = $urandom % 2;
            setc({ctrl[31:2], rnd[0], 1'b0});
            rd(OFF_STATUS, {28'h0, rnd[0], 3'b000});
            chk("out2", {31'h0, rnd[0]}, {31'h0, out2});
        end
        $display("test enable done");
        wr(OFF_LIMIT, 32'h5);
        setc(32'h14);
        ld(32'h5);
        step(2'h1, 1'b1, 8'h1, 32'h0, 3'b001);
        step(2'h2, 1'b0, 8'h1, 32'h5, 3'b010);
        setc(32'h10);
        ld(32'h5);
        step(2'h1, 1'b1, 8'h1, 32'h6, 3'b010);
        ld(32'hffffffff);
        step(2'h1, 1'b1, 8'h1, 32'h0, 3'b001);
        ld(32'h0);
        step(2'h2, 1'b0, 8'h1, 32'hffffffff, 3'b010);
        ld(32'h3fff);
        step(2'h1, 1'b1, 8'h1, 32'h4000, 3'b000);
        ld(32'hffffffff);
        step(2'h1, 1'b1, 8'h1, 32'h0, 3'b001);
        ld(32'hffffc001);
        step(2'h2, 1'b0, 8'h1, 32'hffffc000, 3'b000);
        $display("test wrap done");
        end_of_test();
    end
endmodule

`default_nettype wire
